// [verilog/cpl_carrier_prog_lock_bank_ctrl.sv]
// Functional notes
// RULE1 - fixed frequencies: writes rejected with error
// RULE2 - fixed gain: writes rejected, else writable
// RULE3 - key bits 31:16 read zero; c705 locks
// RULE4 - key 5e5a unlocks
// RULE5 - lock flag bit 0; locked writes error
// RULE6 - guard always writable; bad keys ignored
// RULE7 - port reset clears lock
// RULE8 - bank bit 0 selects active bank
// RULE9 - active bank read-only, shadow freq/gain read/write, shadow phase read-only
// RULE10 - datapath uses active bank values only
// RULE11 - accepted bank write resets datapath
// RULE12 - valid low until fresh samples emerge
// RULE13 - bank reset keeps sample history
// RULE14 - port reset keeps bank choice
// RULE15 - frequency registers start at quantized frequency
// RULE16 - phase registers start at quantized phase
// RULE17 - host swaps banks only when idle
// RULE18 - report holds IF, standard, type
// RULE19 - report bits 25:20 hold bandwidth code
// RULE20 - report bit 14 shows gain option
// RULE21 - report bit 13 reads zero
// RULE22 - report bit 12 shows frequency option
// RULE23 - ready every access; error only on rejects
`timescale 1ns/1ns
`default_nettype none
module cpl_carrier_prog_lock_bank_ctrl #(
  parameter int          NUM_CARRIERS  = 4,
  parameter bit          PROG_FREQ     = 1'b1,
  parameter bit          PROG_GAIN     = 1'b1,
  parameter bit          CORE_IS_DOWN  = 1'b0,
  parameter logic [1:0]  IF_CODE       = 2'h0,
  parameter logic [3:0]  STD_CODE      = 4'h0,
  parameter logic [5:0]  BW_CODE       = 6'h05,
  parameter logic [31:0] FREQ_INIT     = 32'h0000_0000,
  parameter logic [31:0] PHASE_INIT    = 32'h0000_0000
) (
  input  wire logic                        sys_clk,            // system clock
  input  wire logic                        srst,               // datapath reset input
  input  wire logic                        prog_port_reset_n,  // programming port reset
  input  wire logic [11:0]                 paddr,              // apb address
  input  wire logic                        psel,               // apb select
  input  wire logic                        penable,            // apb enable
  input  wire logic                        pwrite,             // apb write
  input  wire logic [31:0]                 pwdata,             // apb write data
  output logic                             pready,             // apb ready
  output logic [31:0]                      prdata,             // apb read data
  output logic                             pslverr,            // apb slave error
  input  wire logic                        in_sample_valid,    // datapath input sample valid
  output logic                             out_stream_valid,   // datapath output valid
  output logic                             datapath_reset_n,   // datapath reset to filters etc.
  output logic [NUM_CARRIERS*32-1:0]       active_freq,        // active bank frequencies
  output logic [NUM_CARRIERS*32-1:0]       active_phase,       // active bank phase offsets
  output logic [NUM_CARRIERS*32-1:0]       active_gain         // active bank gains
);

  initial
  begin
    if (NUM_CARRIERS < 1 || NUM_CARRIERS > 30)
      $error("NUM_CARRIERS must be 1..30");
  end

  localparam int NC = NUM_CARRIERS;

  logic        lock_q;
  logic        bank_q;
  logic [31:0] freq_q  [2][NC];
  logic [31:0] phase_q [2][NC];
  logic [31:0] gain_q  [2][NC];
  logic [3:0]  flush_q;
  logic        dp_rst_q;
  logic        valid_q;
  logic        sync1_q;
  logic        sync2_q;

  // decode of a carrier group: returns carrier index, or -1 if no hit
  function automatic int grp_hit(input logic [11:0] a, input logic [11:0] base);
    logic [11:0] off;
    off = a - base;
    grp_hit = -1;
    if (a >= base && off < cpl_pkg::GROUP_SPAN && off[1:0] == 2'b00 && int'(off[11:2]) < NC)
      grp_hit = int'(off[11:2]);
  endfunction

  logic        acc;
  logic        wr;
  logic        hit_guard;
  logic        hit_bank;
  logic        hit_param;
  logic        wr_ok;
  logic        wr_err;
  logic [31:0] rd_d;
  logic [31:0] param_word;
  int          f_idx [2];
  int          p_idx [2];
  int          g_idx [2];

  assign acc       = psel && penable;
  assign wr        = acc && pwrite;
  assign hit_guard = paddr == cpl_pkg::WRITE_GUARD_OFS;
  assign hit_bank  = paddr == cpl_pkg::ACTIVE_BANK_OFS;
  assign hit_param = paddr == cpl_pkg::CORE_PARAM_OFS;

  always_comb
  begin
    for (int b = 0; b < 2; b++)
    begin
      f_idx[b] = grp_hit(paddr, cpl_pkg::FREQ_A_OFS + (b == 1 ? cpl_pkg::BANK_B_DELTA : 12'h000));
      p_idx[b] = grp_hit(paddr, cpl_pkg::PHASE_A_OFS + (b == 1 ? cpl_pkg::BANK_B_DELTA : 12'h000));
      g_idx[b] = grp_hit(paddr, cpl_pkg::GAIN_A_OFS + (b == 1 ? cpl_pkg::BANK_B_DELTA : 12'h000));
    end
  end

  // parameter report
  always_comb
  begin
    param_word = 32'h0000_0000;
    param_word[cpl_pkg::IF_LSB +: 2]  = IF_CODE;                       // RULE18
    param_word[cpl_pkg::BW_LSB +: 6]  = BW_CODE;                       // RULE19
    param_word[cpl_pkg::STD_LSB +: 4] = STD_CODE;                      // RULE18
    param_word[cpl_pkg::TYPE_BIT]     = CORE_IS_DOWN;                  // RULE18
    param_word[cpl_pkg::GAIN_BIT]     = PROG_GAIN;                     // RULE20
    param_word[cpl_pkg::PHASE_BIT]    = 1'b0;                          // RULE21
    param_word[cpl_pkg::FREQ_BIT]     = PROG_FREQ;                     // RULE22
  end

  // write permission: phase groups are read-only, unmapped writes err
  always_comb
  begin
    wr_ok = 1'b0;
    if (hit_guard)
      wr_ok = 1'b1;                                                    // RULE6
    else if (!lock_q)                                                  // RULE5
    begin
      if (hit_bank)
        wr_ok = 1'b1;
      for (int b = 0; b < 2; b++)
      begin
        if (logic'(b) != bank_q)                                       // RULE9
        begin
          if (f_idx[b] >= 0 && PROG_FREQ)                              // RULE1
            wr_ok = 1'b1;
          if (g_idx[b] >= 0 && PROG_GAIN)                              // RULE2
            wr_ok = 1'b1;
        end
      end
    end
  end

  assign wr_err = wr && !wr_ok;

  always_comb
  begin
    rd_d = 32'h0000_0000;
    if (hit_guard)
      rd_d[cpl_pkg::LOCK_BIT] = lock_q;                                // RULE3
    if (hit_bank)
      rd_d[cpl_pkg::BANK_BIT] = bank_q;
    if (hit_param)
      rd_d = param_word;
    for (int b = 0; b < 2; b++)
    begin
      if (f_idx[b] >= 0)
        rd_d = freq_q[b][f_idx[b]];
      if (p_idx[b] >= 0)
        rd_d = phase_q[b][p_idx[b]];
      if (g_idx[b] >= 0)
        rd_d = gain_q[b][g_idx[b]];
    end
  end

  // zero wait state slave
  assign pready  = 1'b1;                                               // RULE23
  assign pslverr = acc && wr_err;                                      // RULE23

  always_ff @(posedge sys_clk)
  begin
    if (!prog_port_reset_n)
      prdata <= 32'h0000_0000;
    else if (psel && !penable && !pwrite)
      prdata <= rd_d;
  end

  // lock flag
  always_ff @(posedge sys_clk)
  begin
    if (!prog_port_reset_n)
      lock_q <= cpl_pkg::LOCK_RESET;                                   // RULE7
    else if (wr && hit_guard)
    begin
      if (pwdata[cpl_pkg::KEY_LSB +: 16] == cpl_pkg::LOCK_KEY)
        lock_q <= 1'b1;                                                // RULE3
      else if (pwdata[cpl_pkg::KEY_LSB +: 16] == cpl_pkg::UNLOCK_KEY)
        lock_q <= 1'b0;                                                // RULE4
    end
  end

  // bank choice: not touched by the port reset
  always_ff @(posedge sys_clk)
  begin
    if (srst)
      bank_q <= cpl_pkg::BANK_INIT;
    else if (wr && hit_bank && wr_ok)
      bank_q <= pwdata[cpl_pkg::BANK_BIT];                             // RULE8 RULE14
  end

  // carrier banks: initial values, not cleared by the port reset
  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      for (int b = 0; b < 2; b++)
        for (int c = 0; c < NC; c++)
        begin
          freq_q[b][c]  <= FREQ_INIT;                                  // RULE15
          phase_q[b][c] <= PHASE_INIT;                                 // RULE16
          gain_q[b][c]  <= cpl_pkg::GAIN_RESET;
        end
    end
    else if (wr && wr_ok)
    begin
      for (int b = 0; b < 2; b++)
      begin
        if (f_idx[b] >= 0)
          freq_q[b][f_idx[b]] <= pwdata;
        if (g_idx[b] >= 0)
          gain_q[b][g_idx[b]] <= pwdata;
      end
    end
  end

  // active bank to datapath
  always_comb
  begin
    for (int c = 0; c < NC; c++)
    begin
      active_freq[c*32 +: 32]  = freq_q[bank_q][c];                    // RULE10
      active_phase[c*32 +: 32] = phase_q[bank_q][c];                   // RULE10
      active_gain[c*32 +: 32]  = gain_q[bank_q][c];                    // RULE10
    end
  end

  // internal datapath reset: one-cycle pulse after a bank write, held high while srst is high
  always_ff @(posedge sys_clk)
  begin
    if (srst)
      dp_rst_q <= 1'b1;
    else
      dp_rst_q <= wr && hit_bank && wr_ok;                             // RULE11
  end

  // history pipelines are not wired to this reset; only control state is
  assign datapath_reset_n = !dp_rst_q;                                 // RULE13

  always_ff @(posedge sys_clk)
  begin
    sync1_q <= in_sample_valid;
    sync2_q <= sync1_q;
  end

  // valid recovery: counts fresh input samples through the pipe
  always_ff @(posedge sys_clk)
  begin
    if (srst || dp_rst_q)
    begin
      flush_q <= 4'h0;                                                 // RULE12
      valid_q <= 1'b0;                                                 // RULE12
    end
    else if (sync2_q && !valid_q)
    begin
      if (flush_q == 4'(cpl_pkg::FLUSH_CYCLES - 1))
        valid_q <= 1'b1;
      flush_q <= flush_q + 4'h1;
    end
  end

  assign out_stream_valid = valid_q;

endmodule
`default_nettype wire

// [verilog/cpl_pkg.sv]
package cpl_pkg;
  // register offsets (12-bit byte addresses)
  localparam logic [11:0] WRITE_GUARD_OFS    = 12'h000;
  localparam logic [11:0] ACTIVE_BANK_OFS    = 12'h004;
  localparam logic [11:0] CORE_PARAM_OFS     = 12'h080;
  localparam logic [11:0] FREQ_A_OFS         = 12'h100;
  localparam logic [11:0] PHASE_A_OFS        = 12'h200;
  localparam logic [11:0] GAIN_A_OFS         = 12'h300;
  localparam logic [11:0] BANK_B_DELTA       = 12'h400;
  localparam logic [11:0] GROUP_SPAN         = 12'h100;
  // guard and bank register fields
  localparam int          KEY_LSB            = 16;
  localparam logic [15:0] LOCK_KEY           = 16'hc705;
  localparam logic [15:0] UNLOCK_KEY         = 16'h5e5a;
  localparam int          LOCK_BIT           = 0;
  localparam logic        LOCK_RESET         = 1'b0;
  localparam int          BANK_BIT           = 0;
  localparam logic        BANK_INIT          = 1'b0;
  // parameter report fields
  localparam int          IF_LSB             = 26;
  localparam int          BW_LSB             = 20;
  localparam int          STD_LSB            = 16;
  localparam int          TYPE_BIT           = 15;
  localparam int          GAIN_BIT           = 14;
  localparam int          PHASE_BIT          = 13;
  localparam int          FREQ_BIT           = 12;
  localparam logic [31:0] GAIN_RESET         = 32'h0001_0000;
  // fixed depth of the output-valid recovery pipe after a datapath reset
  localparam int          FLUSH_CYCLES       = 8;
endpackage

// [verif/cpl_monitor.sv]
`timescale 1ns/1ns
`default_nettype none
module cpl_monitor #(
  parameter bit PROG_FREQ = 1'b1,
  parameter bit PROG_GAIN = 1'b1
) (
  input wire logic        sys_clk,           // clock
  input wire logic        srst,              // datapath reset
  input wire logic        prog_port_reset_n, // port reset
  input wire logic [11:0] paddr,             // address
  input wire logic        psel,              // select
  input wire logic        penable,           // enable
  input wire logic        pwrite,            // direction
  input wire logic [31:0] pwdata,            // write data
  input wire logic        pready,            // ready
  input wire logic [31:0] prdata,            // read data
  input wire logic        pslverr,           // error
  input wire logic        out_stream_valid,  // output valid
  input wire logic        datapath_reset_n   // datapath reset out
);
  logic lock_q;
  logic bank_q;
  logic wr_acc;
  logic rd_acc;
  assign wr_acc = psel && penable && pwrite;
  assign rd_acc = psel && penable && !pwrite;
  always_ff @(posedge sys_clk)
  begin
    if (!prog_port_reset_n)
      lock_q <= 1'b0;
    else if (wr_acc && paddr == 12'h000 && pwdata[31:16] == cpl_pkg::LOCK_KEY)
      lock_q <= 1'b1;
    else if (wr_acc && paddr == 12'h000 && pwdata[31:16] == cpl_pkg::UNLOCK_KEY)
      lock_q <= 1'b0;
  end
  always_ff @(posedge sys_clk)
  begin
    if (srst)
      bank_q <= 1'b0;
    else if (wr_acc && paddr == 12'h004 && !pslverr)
      bank_q <= pwdata[0];
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (srst || !prog_port_reset_n);
  a_ready_every: assert property (psel && penable |-> pready)
    else $error("ready missing in access phase");
  a_err_cause: assert property (pslverr |-> wr_acc)
    else $error("error outside a write access");
  a_locked_reject: assert property (wr_acc && lock_q && paddr != 12'h000 |-> pslverr)
    else $error("locked write accepted");
  a_guard_open: assert property (wr_acc && paddr == 12'h000 |-> !pslverr)
    else $error("guard write refused");
  a_active_reject: assert property (wr_acc && paddr[11:8] == {1'b0, bank_q, 2'b01} |-> pslverr)
    else $error("active bank write accepted");
  a_gain_fixed: assert property (wr_acc && !PROG_GAIN && !paddr[11] && paddr[9:8] == 2'h3 |-> pslverr)
    else $error("fixed gain write accepted");
  a_bank_reset: assert property (wr_acc && paddr == 12'h004 && !pslverr |=> !datapath_reset_n)
    else $error("no datapath reset after bank write");
  a_valid_drop: assert property (wr_acc && paddr == 12'h004 && !pslverr |-> ##2 !out_stream_valid)
    else $error("valid kept after bank write");
  a_report_flags: assert property (rd_acc && paddr == 12'h080 |-> prdata[14:12] == {PROG_GAIN, 1'b0, PROG_FREQ})
    else $error("report option bits wrong");
  a_guard_read: assert property (rd_acc && paddr == 12'h000 |-> prdata == {31'h0, lock_q})
    else $error("guard read wrong");
endmodule
bind cpl_carrier_prog_lock_bank_ctrl cpl_monitor #(.PROG_FREQ(PROG_FREQ), .PROG_GAIN(PROG_GAIN))
  u_cpl_monitor (.sys_clk, .srst, .prog_port_reset_n, .paddr, .psel, .penable, .pwrite, .pwdata,
  .pready, .prdata, .pslverr, .out_stream_valid, .datapath_reset_n);
`default_nettype wire

// [verif/cpl_apb_host.sv]
`timescale 1ns/1ns
`default_nettype none
module cpl_apb_host (
  input  wire logic        sys_clk, // clock
  input  wire logic        pready,  // ready
  input  wire logic [31:0] prdata,  // read data
  input  wire logic        pslverr, // error
  output var  logic        psel,    // select
  output var  logic        penable, // enable
  output var  logic        pwrite,  // direction
  output var  logic [11:0] paddr,   // address
  output var  logic [31:0] pwdata   // write data
);
  initial
  begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h0;
    pwdata = 32'h0;
  end
  // called just after a rising edge; ends one idle edge after release
  task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] rd, output logic err, output logic ok);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    do
    begin
      @(posedge sys_clk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    ok = pready;
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    paddr <= ~a;
    pwdata <= ~d;
    @(posedge sys_clk);
  endtask
endmodule
`default_nettype wire

// [verif/tb_top.sv]
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  typedef struct packed {logic w; logic [11:0] a; logic [31:0] d; logic [31:0] x; logic e;} cpl_row_s;
  logic sys_clk, srst, prog_port_reset_n, in_sample_valid, psel, penable, pwrite, pready, pslverr;
  logic out_stream_valid, datapath_reset_n, er;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [127:0] active_freq, active_phase;
  int fail_count = 0;
  int total_checks = 0;
  cpl_row_s rows [22];
  cpl_carrier_prog_lock_bank_ctrl #(.PROG_GAIN(1'b0), .CORE_IS_DOWN(1'b1), .IF_CODE(2'h1),
    .FREQ_INIT(32'h11), .PHASE_INIT(32'h22))
    u_cpl_carrier_prog_lock_bank_ctrl (.sys_clk, .srst, .prog_port_reset_n, .paddr, .psel,
    .penable, .pwrite, .pwdata, .pready, .prdata, .pslverr, .in_sample_valid, .out_stream_valid,
    .datapath_reset_n, .active_freq, .active_phase, .active_gain());
  cpl_apb_host u_cpl_apb_host (.sys_clk, .pready, .prdata, .pslverr, .psel, .penable, .pwrite,
    .paddr, .pwdata);
  task automatic complete_run();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] g);
    total_checks++;
    if (g !== x)
    begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, x, g);
    end
  endtask
  task automatic acc(input logic w, input logic [11:0] a, input logic [31:0] d, input logic e);
    logic ok;
    u_cpl_apb_host.xfer(w, a, d, rd, er, ok);
    chk("ready", 32'h1, {31'h0, ok});
    if (ok !== 1'b1)
      complete_run();
    chk("slverr", {31'h0, e}, {31'h0, er});
  endtask
  initial
  begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  initial
  begin
    srst = 1'b1;
    prog_port_reset_n = 1'b0;
    in_sample_valid = 1'b0;
    rows = '{'{1'b0, 12'h080, 32'h0, 32'h04509000, 1'b0},
      '{1'b0, 12'h000, 32'h0, 32'h0, 1'b0},
      '{1'b0, 12'h004, 32'h0, 32'h0, 1'b0},
      '{1'b0, 12'h100, 32'h0, 32'h11, 1'b0},
      '{1'b0, 12'h200, 32'h0, 32'h22, 1'b0},
      '{1'b0, 12'h300, 32'h0, 32'h00010000, 1'b0},
      '{1'b1, 12'h100, 32'h5, 32'h0, 1'b1},
      '{1'b1, 12'h500, 32'h55, 32'h0, 1'b0},
      '{1'b0, 12'h500, 32'h0, 32'h55, 1'b0},
      '{1'b1, 12'h700, 32'h1, 32'h0, 1'b1},
      '{1'b1, 12'h504, 32'h66, 32'h0, 1'b0},
      '{1'b1, 12'h000, 32'hc7050001, 32'h0, 1'b0},
      '{1'b0, 12'h000, 32'h0, 32'h1, 1'b0},
      '{1'b1, 12'h508, 32'h1, 32'h0, 1'b1},
      '{1'b1, 12'h000, 32'h12340000, 32'h0, 1'b0},
      '{1'b0, 12'h000, 32'h0, 32'h1, 1'b0},
      '{1'b1, 12'h004, 32'h1, 32'h0, 1'b1},
      '{1'b1, 12'h000, 32'h5e5a0000, 32'h0, 1'b0},
      '{1'b0, 12'h000, 32'h0, 32'h0, 1'b0},
      '{1'b1, 12'h508, 32'h77, 32'h0, 1'b0},
      '{1'b1, 12'hffc, 32'h1, 32'h0, 1'b1},
      '{1'b0, 12'hffc, 32'h0, 32'h0, 1'b0}};
    repeat (12) @(posedge sys_clk);
    srst <= 1'b0;
    prog_port_reset_n <= 1'b1;
    @(posedge sys_clk);
    foreach (rows[i])
    begin
      acc(rows[i].w, rows[i].a, rows[i].d, rows[i].e);
      if (!rows[i].w)
        chk("rdata", rows[i].x, rd & (rows[i].a == 12'h080 ? 32'hfffff000 : 32'hffffffff));
    end
    $display("test table done");
    in_sample_valid <= 1'b1;
    repeat (30) @(posedge sys_clk);
    in_sample_valid <= 1'b0;
    @(negedge sys_clk);
    chk("valid up", 32'h1, {31'h0, out_stream_valid});
    @(posedge sys_clk);
    acc(1'b1, 12'h004, 32'h1, 1'b0);
    @(negedge sys_clk);
    chk("valid down", 32'h0, {31'h0, out_stream_valid});
    chk("freq0", 32'h55, active_freq[31:0]);
    chk("freq2", 32'h77, active_freq[95:64]);
    chk("phase0", 32'h22, active_phase[31:0]);
    @(posedge sys_clk);
    acc(1'b0, 12'h004, 32'h0, 1'b0);
    chk("bank", 32'h1, rd);
    acc(1'b1, 12'h100, 32'h9, 1'b0);
    acc(1'b1, 12'h500, 32'h9, 1'b1);
    acc(1'b1, 12'h004, 32'h1, 1'b0);
    $display("test bank swap done");
    acc(1'b1, 12'h000, 32'hc7050000, 1'b0);
    prog_port_reset_n <= 1'b0;
    @(posedge sys_clk);
    prog_port_reset_n <= 1'b1;
    @(posedge sys_clk);
    acc(1'b0, 12'h000, 32'h0, 1'b0);
    chk("lock after port reset", 32'h0, rd);
    acc(1'b0, 12'h004, 32'h0, 1'b0);
    chk("bank after port reset", 32'h1, rd);
    $display("test port reset done");
    complete_run();
  end
endmodule
`default_nettype wire
